// [rtl/seq_loop_pkg.sv]
package seq_loop_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_REPEAT = 8'hc9;
  localparam logic [7:0] ADDR_REFRESH = 8'hca;
  localparam logic [7:0] ADDR_SCL_LOW = 8'hcb;
  localparam logic [7:0] ADDR_SCL_HIGH = 8'hcc;
  localparam logic [7:0] RST_REPEAT = 8'h01;
  localparam logic [7:0] RST_REFRESH = 8'h00;
  localparam logic [7:0] RST_SCL_LOW = 8'h5e;
  localparam logic [7:0] RST_SCL_HIGH = 8'h3f;
  // ****************************************
  // Timing classes
  // ****************************************
  localparam logic [1:0] CLASS_STD = 2'h0;
  localparam logic [1:0] CLASS_FAST = 2'h1;
  localparam logic [1:0] CLASS_FMP = 2'h2;
  localparam int SCALE_STD = 8;
  localparam int SCALE_FAST = 4;
  localparam int SCALE_FMP = 1;
  // Minimum high and low counts in PLL periods, after scaling
  localparam int MIN_LOW_STD = 744;
  localparam int MIN_HIGH_STD = 632;
  localparam int MIN_LOW_FAST = 208;
  localparam int MIN_HIGH_FAST = 96;
  localparam int MIN_LOW_FMP = 81;
  localparam int MIN_HIGH_FMP = 42;
  // Slowest allowed clock, 50 kHz at 156 MHz: 3120 PLL periods per cycle
  localparam int PLL_MHZ = 156;
  localparam int MIN_SCL_KHZ = 50;
  localparam int MAX_SCL_PERIOD = (PLL_MHZ * 1000) / MIN_SCL_KHZ;
  // ****************************************
  // Refresh tick
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int REFRESH_UNIT_US = 100;
  localparam int REFRESH_UNIT_CYCLES = REFRESH_UNIT_US * CLK_MHZ;
  localparam int RISE_LIMIT = 64;
endpackage

// [rtl/scl_timer.sv]
`timescale 1ns/100ps
module scl_timer
  import seq_loop_pkg::*;
(
  input wire logic pll_clk_en,
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [1:0] timing_class_select,
  input wire logic [7:0] scl_low_count,
  input wire logic [7:0] scl_high_count,
  input wire logic scl_in_sync,
  output logic scl_drive_low,
  output logic cycle_done
);
  // ****************************************
  // Scaled phase lengths
  // ****************************************
  logic [11:0] low_len, high_len, min_low, min_high, want_low, want_high;
  logic [11:0] cnt_reg, rise_reg;
  logic phase_high_reg;

  function automatic logic [11:0] scale(input logic [7:0] v, input logic [1:0] c);
    if (c == CLASS_STD) scale = {v, 3'h0} + 12'h000;
    else if (c == CLASS_FAST) scale = {2'h0, v, 2'h0};
    else scale = {4'h0, v};
  endfunction

  always_comb begin
    if (timing_class_select == CLASS_STD) begin
      min_low = 12'(MIN_LOW_STD);
      min_high = 12'(MIN_HIGH_STD);
    end else if (timing_class_select == CLASS_FAST) begin
      min_low = 12'(MIN_LOW_FAST);
      min_high = 12'(MIN_HIGH_FAST);
    end else begin
      min_low = 12'(MIN_LOW_FMP);
      min_high = 12'(MIN_HIGH_FMP);
    end
    want_low = scale(scl_low_count, timing_class_select);
    want_high = scale(scl_high_count, timing_class_select);
    // Illegal values fall back to the class minimums
    low_len = (want_low < min_low) ? min_low : want_low;
    high_len = (want_high < min_high) ? min_high : want_high;
    // Cap so the bus never runs below the slowest supported rate
    if (low_len + high_len > 12'(MAX_SCL_PERIOD)) begin
      low_len = 12'(MAX_SCL_PERIOD / 2);
      high_len = 12'(MAX_SCL_PERIOD / 2);
    end
  end

  // ****************************************
  // Phase counter, PLL-period steps
  // ****************************************
  // Rise time is absorbed into the high phase; counting starts once SCL is seen high or after RISE_LIMIT periods of waiting
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 12'h000;
      rise_reg <= 12'h000;
      phase_high_reg <= 1'b0;
      cycle_done <= 1'b0;
    end else begin
      cycle_done <= 1'b0;
      if (!run) begin
        cnt_reg <= 12'h000;
        rise_reg <= 12'h000;
        phase_high_reg <= 1'b0;
      end else if (pll_clk_en) begin
        if (!phase_high_reg) begin
          if (cnt_reg + 12'h001 >= low_len) begin
            phase_high_reg <= 1'b1;
            cnt_reg <= 12'h000;
            rise_reg <= 12'h000;
          end else cnt_reg <= cnt_reg + 12'h001;
        end else if (!scl_in_sync && rise_reg < 12'(RISE_LIMIT)) begin
          rise_reg <= rise_reg + 12'h001;
        end else if (cnt_reg + rise_reg + 12'h001 >= high_len
                     && cnt_reg + 12'h001 >= min_high) begin
          phase_high_reg <= 1'b0;
          cnt_reg <= 12'h000;
          cycle_done <= 1'b1;
        end else cnt_reg <= cnt_reg + 12'h001;
      end
    end
  end

  assign scl_drive_low = run && !phase_high_reg;
endmodule // scl_timer

// [rtl/seq_loop_ctrl.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - Repeat count register reads programmed value
// - Count zero replays sequence forever
// - Count one sends sequence once
// - Count above one sends that many
// - Looping applies only to buffered sequence
// - Refresh timer needs count not one
// - Refresh period counts 100 us units
// - Zero period means back-to-back passes
// - Overrun sets frame error, requests interrupt
// - Low count resets to 94
// - High count resets to 63
// - SCL counted in PLL clock periods
// - Counts scaled eight, four or one
// - Illegal counts fall back to minimums
// - Rise time monitored, minimums still kept
// - Reset selects fast-mode plus timing
// - Serial clock never below 50 kHz
// - Class field encodes the three modes
module seq_loop_ctrl
  import seq_loop_pkg::*;
#(
  parameter int REFRESH_UNIT = REFRESH_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] timing_class_select,
  input wire logic trigger_enable,
  input wire logic pll_clk_en,
  input wire logic start_buffer_seq,
  input wire logic seq_busy,
  input wire logic frame_error_clear,
  input wire logic scl_in,
  output logic pass_start,
  output logic stop_request,
  output logic loop_active,
  output logic frame_error_flag,
  output logic int_request,
  output logic scl_drive_low,
  output logic scl_cycle_done,
  output logic [7:0] pass_count
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] sequence_repeat_count_reg, refresh_period_reg, scl_low_count_reg;
  logic [7:0] scl_high_count_reg;
  logic [1:0] class_reg;
  logic [1:0] scl_sync_reg;
  logic [15:0] unit_cnt_reg;
  logic [7:0] period_cnt_reg;
  logic [7:0] pass_cnt_reg;
  logic busy_d_reg, start_pend_reg, timer_on, pass_end, period_hit, more_passes;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sequence_repeat_count_reg <= RST_REPEAT;
      refresh_period_reg <= RST_REFRESH;
      scl_low_count_reg <= RST_SCL_LOW;
      scl_high_count_reg <= RST_SCL_HIGH;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_REPEAT) sequence_repeat_count_reg <= reg_wdata;
      else if (reg_addr == ADDR_REFRESH) refresh_period_reg <= reg_wdata;
      else if (reg_addr == ADDR_SCL_LOW) scl_low_count_reg <= reg_wdata;
      else if (reg_addr == ADDR_SCL_HIGH) scl_high_count_reg <= reg_wdata;
    end
  end

  // Readback is the stored value, not the live pass count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) reg_rdata <= 8'h00;
    else if (reg_rd) begin
      if (reg_addr == ADDR_REPEAT) reg_rdata <= sequence_repeat_count_reg;
      else if (reg_addr == ADDR_REFRESH) reg_rdata <= refresh_period_reg;
      else if (reg_addr == ADDR_SCL_LOW) reg_rdata <= scl_low_count_reg;
      else if (reg_addr == ADDR_SCL_HIGH) reg_rdata <= scl_high_count_reg;
      else reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Timing class
  // ****************************************
  // Reserved code 11 keeps the previous class
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) class_reg <= CLASS_FMP;
    else if (timing_class_select != 2'h3) class_reg <= timing_class_select;
  end

  // ****************************************
  // Pass sequencing
  // ****************************************
  assign pass_end = busy_d_reg && !seq_busy;
  assign timer_on = (sequence_repeat_count_reg != 8'h01) && !trigger_enable
                    && (refresh_period_reg != 8'h00);
  assign period_hit = timer_on && loop_active && pll_tick_unit(unit_cnt_reg)
                      && (period_cnt_reg + 8'h01 >= refresh_period_reg);
  assign more_passes = (sequence_repeat_count_reg == 8'h00)
                       || (pass_cnt_reg + 8'h01 < sequence_repeat_count_reg);

  // Counter passed in so continuous assignments see it change
  function automatic logic pll_tick_unit(input logic [15:0] c);
    pll_tick_unit = (c == 16'(REFRESH_UNIT - 1));
  endfunction

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busy_d_reg <= 1'b0;
    else busy_d_reg <= seq_busy;
  end

  // Only the buffered sequence start enters the loop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loop_active <= 1'b0;
      pass_cnt_reg <= 8'h00;
      start_pend_reg <= 1'b0;
      pass_start <= 1'b0;
      stop_request <= 1'b0;
    end else begin
      pass_start <= 1'b0;
      stop_request <= 1'b0;
      if (start_buffer_seq && !loop_active) begin
        loop_active <= 1'b1;
        pass_cnt_reg <= 8'h00;
        pass_start <= 1'b1;
      end else if (loop_active) begin
        if (pass_end) begin
          stop_request <= 1'b1;
          if (more_passes) begin
            pass_cnt_reg <= pass_cnt_reg + 8'h01;
            if (timer_on) start_pend_reg <= 1'b1;
            else pass_start <= 1'b1;
          end else loop_active <= 1'b0;
        end else if (start_pend_reg && period_hit) begin
          start_pend_reg <= 1'b0;
          pass_start <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Refresh timer
  // ****************************************
  // 16-bit prescaler covers 100 us at up to 655 MHz
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      unit_cnt_reg <= 16'h0000;
      period_cnt_reg <= 8'h00;
    end else if (!timer_on || !loop_active) begin
      unit_cnt_reg <= 16'h0000;
      period_cnt_reg <= 8'h00;
    // Cycle of pass_start already counts, so start to start is exactly the period
    end else if (pll_tick_unit(unit_cnt_reg)) begin
      unit_cnt_reg <= 16'h0000;
      period_cnt_reg <= period_hit ? 8'h00 : period_cnt_reg + 8'h01;
    end else unit_cnt_reg <= unit_cnt_reg + 16'h0001;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) frame_error_flag <= 1'b0;
    else if (period_hit && seq_busy) frame_error_flag <= 1'b1;
    else if (frame_error_clear) frame_error_flag <= 1'b0;
  end

  assign int_request = frame_error_flag;
  assign pass_count = pass_cnt_reg;

  // ****************************************
  // SCL generation
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) scl_sync_reg <= 2'h3;
    else scl_sync_reg <= {scl_sync_reg[0], scl_in};
  end

  scl_timer u_scl_timer (
    .pll_clk_en(pll_clk_en),
    .clk(clk),
    .sys_rst(sys_rst),
    .run(seq_busy),
    .timing_class_select(class_reg),
    .scl_low_count(scl_low_count_reg),
    .scl_high_count(scl_high_count_reg),
    .scl_in_sync(scl_sync_reg[1]),
    .scl_drive_low(scl_drive_low),
    .cycle_done(scl_cycle_done)
  );
endmodule // seq_loop_ctrl

// [verif/seq_partner.sv]
`timescale 1ns/100ps
module seq_partner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pass_start,
  input wire logic scl_drive_low,
  input wire logic [15:0] busy_len,
  output logic seq_busy,
  output logic scl_in
);
  logic [15:0] left_reg;
  logic [1:0] rise_reg;
  // Each pass holds the bus for busy_len cycles; the bench picks it against the period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) left_reg <= 16'h0000;
    else if (pass_start) left_reg <= busy_len;
    else if (left_reg != 16'h0000) left_reg <= left_reg - 16'h0001;
  end
  assign seq_busy = (left_reg != 16'h0000);
  // Pull-up needs two cycles to lift SCL, so the rise-time logic has work to do
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rise_reg <= 2'h3;
    else rise_reg <= {rise_reg[0], ~scl_drive_low};
  end
  assign scl_in = ~scl_drive_low & rise_reg[1];
endmodule // seq_partner

// [verif/seq_loop_assertions.sv]
`timescale 1ns/100ps
module seq_loop_assertions
  import seq_loop_pkg::*;
#(
  parameter int REFRESH_UNIT = REFRESH_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic start_buffer_seq,
  input wire logic seq_busy,
  input wire logic frame_error_clear,
  input wire logic pass_start,
  input wire logic stop_request,
  input wire logic loop_active,
  input wire logic frame_error_flag,
  input wire logic int_request,
  input wire logic scl_drive_low,
  input wire logic [7:0] pass_count
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_pass_end;
    $fell(seq_busy) ##0 loop_active;
  endsequence
  a_start_taken: assert property (start_buffer_seq && !loop_active |=> pass_start && loop_active)
    else $error("buffered run did not start");
  a_stop_after_pass: assert property (s_pass_end |-> ##[1:2] stop_request)
    else $error("no stop after pass end");
  a_int_follows_flag: assert property (int_request == frame_error_flag)
    else $error("interrupt request differs from frame error");
  a_flag_sticky: assert property (frame_error_flag && !frame_error_clear |=> frame_error_flag)
    else $error("frame error dropped without clear");
  a_unmapped_read: assert property (reg_rd
    && (reg_addr < ADDR_REPEAT || reg_addr > ADDR_SCL_HIGH) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_count_cleared: assert property (pass_start && !$past(loop_active) |-> pass_count == 8'h00)
    else $error("pass counter not cleared at run start");
  a_drive_in_pass: assert property (scl_drive_low |-> seq_busy)
    else $error("SCL driven outside a pass");
  // Length of the current low phase in clock cycles, saturating
  logic [11:0] low_run_reg;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) low_run_reg <= 12'h000;
    else if (!scl_drive_low) low_run_reg <= 12'h000;
    else if (low_run_reg != 12'hfff) low_run_reg <= low_run_reg + 12'h001;
  end
  a_low_min_kept: assert property ($fell(scl_drive_low) && seq_busy
    |-> low_run_reg >= 12'(MIN_LOW_FMP))
    else $error("SCL low phase shorter than the minimum");
  a_flag_in_pass: assert property ($rose(frame_error_flag)
    |-> $past(seq_busy) && $past(loop_active))
    else $error("frame error set outside a running pass");
endmodule // seq_loop_assertions
bind seq_loop_ctrl seq_loop_assertions #(.REFRESH_UNIT(REFRESH_UNIT)) u_seq_loop_assertions (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .start_buffer_seq(start_buffer_seq), .seq_busy(seq_busy), .frame_error_clear(frame_error_clear),
  .pass_start(pass_start), .stop_request(stop_request), .loop_active(loop_active),
  .frame_error_flag(frame_error_flag), .int_request(int_request),
  .scl_drive_low(scl_drive_low), .pass_count(pass_count));

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import seq_loop_pkg::*;
  localparam int UNIT = 10;
  logic clk, sys_rst, reg_wr, reg_rd, trigger_enable, pll_clk_en, start_buffer_seq;
  logic frame_error_clear, seq_busy, scl_in, pass_start, stop_request, loop_active;
  logic frame_error_flag, int_request, scl_drive_low, scl_cycle_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pass_count, rd_val, v;
  logic [1:0] timing_class_select;
  logic [15:0] busy_len;
  int failures, checked, starts, stops, gap, last_s, cyc, dgap, last_d;
  seq_loop_ctrl #(.REFRESH_UNIT(UNIT)) u_seq_loop_ctrl (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .timing_class_select(timing_class_select),
    .trigger_enable(trigger_enable), .pll_clk_en(pll_clk_en),
    .start_buffer_seq(start_buffer_seq), .seq_busy(seq_busy),
    .frame_error_clear(frame_error_clear), .scl_in(scl_in), .pass_start(pass_start),
    .stop_request(stop_request), .loop_active(loop_active),
    .frame_error_flag(frame_error_flag), .int_request(int_request),
    .scl_drive_low(scl_drive_low), .scl_cycle_done(scl_cycle_done), .pass_count(pass_count));
  seq_partner u_seq_partner (.clk(clk), .sys_rst(sys_rst), .pass_start(pass_start),
    .scl_drive_low(scl_drive_low), .busy_len(busy_len), .seq_busy(seq_busy), .scl_in(scl_in));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (pass_start === 1'b1) begin
      starts++;
      gap = cyc - last_s;
      last_s = cyc;
    end
    if (stop_request === 1'b1) stops++;
    if (scl_cycle_done === 1'b1) begin
      dgap = cyc - last_d;
      last_d = cyc;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge clk) #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge clk) #1 reg_rd = 1'b0;
    @(posedge clk) #1 rd_val = reg_rdata;
  endtask
  task automatic pulse_reset();
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
  endtask
  // Endless runs (repeat zero) are cut by the observation window, not by completion
  task automatic run(input logic [7:0] rep, input logic [7:0] per, input int blen, input int lim);
    int i;
    wr(ADDR_REPEAT, rep);
    wr(ADDR_REFRESH, per);
    busy_len = blen[15:0];
    {starts, stops} = 64'h0;
    @(posedge clk) #1 start_buffer_seq = 1'b1;
    @(posedge clk) #1 start_buffer_seq = 1'b0;
    // Look after the edge has settled, then let one more edge count the last stop
    for (i = 0; i < lim && (loop_active === 1'b1 || i < 2); i++) @(posedge clk) #1;
    @(posedge clk) #1;
    if (rep != 8'h00 && i == lim) begin
      failures++;
      $display("unexpected at %0t: run never finished", $time);
      complete_run();
    end
  endtask
  function automatic int scl_exp(input logic [1:0] c, input int lo, input int hi);
    int s, ml, mh, p;
    s = (c == CLASS_STD) ? SCALE_STD : (c == CLASS_FAST) ? SCALE_FAST : SCALE_FMP;
    ml = (c == CLASS_STD) ? MIN_LOW_STD : (c == CLASS_FAST) ? MIN_LOW_FAST : MIN_LOW_FMP;
    mh = (c == CLASS_STD) ? MIN_HIGH_STD : (c == CLASS_FAST) ? MIN_HIGH_FAST : MIN_HIGH_FMP;
    p = ((lo * s < ml) ? ml : lo * s) + ((hi * s < mh) ? mh : hi * s);
    return (p > MAX_SCL_PERIOD) ? MAX_SCL_PERIOD : p;
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] adr [4] = '{ADDR_REPEAT, ADDR_REFRESH, ADDR_SCL_LOW, ADDR_SCL_HIGH};
    logic [7:0] rsv [4] = '{RST_REPEAT, RST_REFRESH, RST_SCL_LOW, RST_SCL_HIGH};
    logic [1:0] cls [5] = '{CLASS_FMP, CLASS_FAST, CLASS_STD, CLASS_STD, 2'h3};
    int lo [5] = '{94, 59, 20, 255, 20};
    int hi [5] = '{63, 39, 20, 255, 20};
    logic [1:0] ec;
    void'($urandom(32'h95585e8f));
    {reg_wr, reg_rd, trigger_enable, start_buffer_seq, frame_error_clear} = 5'h00;
    {reg_addr, reg_wdata, busy_len} = 32'h0;
    {failures, checked, cyc, last_s, last_d, dgap} = 192'h0;
    pll_clk_en = 1'b1;
    timing_class_select = CLASS_FMP;
    pulse_reset();
    for (int k = 0; k < 4; k++) begin
      rd(adr[k]);
      check(rd_val, rsv[k]);
      v = 8'($urandom);
      wr(adr[k], v);
      rd(adr[k]);
      check(rd_val, v);
    end
    rd(8'hc8);
    check(rd_val, 8'h00);
    pulse_reset();
    run(8'h01, 8'h00, 20, 300);
    check(starts, 1);
    check(stops, 1);
    run(8'h03, 8'h00, 8 + $urandom % 16, 600);
    check(starts, 3);
    check(stops, 3);
    run(8'h00, 8'h00, 20, 300);
    check(starts >= 5, 1);
    pulse_reset();
    run(8'h02, 8'h02, 5, 300);
    check(gap, 2 * UNIT);
    check(frame_error_flag, 1'b0);
    run(8'h02, 8'h01, 30, 300);
    check({frame_error_flag, int_request}, 2'b11);
    @(posedge clk) #1 frame_error_clear = 1'b1;
    @(posedge clk) #1 frame_error_clear = 1'b0;
    @(posedge clk) #1 check(frame_error_flag, 1'b0);
    // Trigger mode switches the refresh timer off: back-to-back, no overrun
    trigger_enable = 1'b1;
    run(8'h02, 8'h01, 30, 300);
    check(starts, 2);
    check(frame_error_flag, 1'b0);
    trigger_enable = 1'b0;
    // Last entry is the reserved code, which keeps the class before it
    for (int k = 0; k < 5; k++) begin
      timing_class_select = cls[k];
      ec = (cls[k] == 2'h3) ? CLASS_STD : cls[k];
      wr(ADDR_SCL_LOW, lo[k][7:0]);
      wr(ADDR_SCL_HIGH, hi[k][7:0]);
      run(8'h01, 8'h00, 7000, 8000);
      check(dgap >= scl_exp(ec, lo[k], hi[k]) && dgap <= scl_exp(ec, lo[k], hi[k]) + 16,
        1);
    end
    complete_run();
  end
endmodule // tb_top
